/* core/sccm_pkg.sv */
// Purpose: Shared constants and types for the system clock mode control block
// Assumes: One synchronous clock domain; oscillators appear as one-cycle tick inputs
// Notes:   Register offsets are word indices on the plain register port

// ****************************************************************************
// Package
// ****************************************************************************
package sccm_pkg;

    // Register port geometry
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned DATA_W      = 8;

    // Register offsets
    localparam logic [3:0] OFF_CTRL     = 4'h0;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h1;
    localparam logic [3:0] OFF_IRQ_EN   = 4'h2;
    localparam logic [3:0] OFF_IRQ_CLR  = 4'h3;

    // Clock select codes
    localparam logic [2:0] SEL_FAST_DIV1 = 3'h0;
    localparam logic [2:0] SEL_SLOW      = 3'h7;
    localparam logic [2:0] SEL_RESET     = 3'h7;

    // Control register: software-writable bits (bit 4 absent, bit 3 read-only)
    localparam logic [7:0] CTRL_WR_MASK  = 8'hE7;
    localparam logic [7:0] CTRL_RESET    = 8'hE0;
    localparam logic [7:0] DATA_ZERO     = 8'h00;

    // Current-clock edges to wait before the hand-over
    localparam logic [2:0] SW_CUR_TICKS  = 3'h4;

    // Default fast oscillator settling, in fast oscillator ticks
    localparam int unsigned STAB_TICKS_DEF = 16;

    // Interrupt status layout
    localparam int unsigned IRQ_W        = 3;
    localparam int unsigned IRQ_STABLE   = 0;
    localparam int unsigned IRQ_SWITCHED = 1;
    localparam int unsigned IRQ_HALTED   = 2;
    localparam logic [IRQ_W-1:0] IRQ_NONE = 3'h0;

    // Control register fields
    typedef struct packed {
        logic [2:0] sys_clk_select;
        logic       unused;
        logic       fast_osc_stable_flag;
        logic       fast_osc_enable;
        logic       fast_osc_keep_in_halt;
        logic       slow_osc_keep_in_halt;
    } sccm_ctrl_t;

    // Clock switch sequencer
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_CUR,
        SW_TGT
    } sccm_sw_state_t;

    // Power state, as driven on the mode output
    typedef enum logic [2:0] {
        PD_RUN,
        PD_SLEEP,
        PD_IDLE0,
        PD_IDLE1,
        PD_IDLE2
    } sccm_pd_mode_t;

endpackage : sccm_pkg

/* core/sccm_divider.sv */
// Purpose: Divides the fast oscillator tick by 1 to 64
// Assumes: fast_tick is a one-cycle pulse per fast oscillator edge
// Notes:   Counter runs freely so the tick phase never jumps on a ratio change

module sccm_divider
    import sccm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Source and ratio
    input  wire logic       fast_tick,
    input  wire logic [2:0] ratio_code,
    // Divided tick
    output logic            div_tick
);

    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [5:0] mask;

    // Ratio 2^code (code 7 gives 64): tick when the low code bits, at most 6, are all ones
    always_comb begin
        mask     = 6'((7'h1 << ratio_code) - 7'h1);
        next_cnt = fast_tick ? 6'(cnt + 6'h1) : cnt;
        div_tick = fast_tick && ((cnt & mask) == mask);
    end

    // Register
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 6'h0;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule // sccm_divider

/* core/sccm_stab.sv */
// Purpose: Tracks settling of the fast oscillator after start or restart
// Assumes: Oscillator ticks only arrive while it runs
// Notes:   A real part would time this in the analog domain; here ticks are counted

module sccm_stab
    import sccm_pkg::*;
#(
    parameter int unsigned STAB_TICKS = STAB_TICKS_DEF
)(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Oscillator state
    input  wire logic osc_on,
    input  wire logic restart,
    input  wire logic fast_tick,
    // Settled indication
    output logic      stable
);

    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        next_stable;

    // Clear first on start or restart, then count settling ticks
    always_comb begin
        next_cnt    = cnt;
        next_stable = stable;
        if (!osc_on || restart) begin
            next_cnt    = 16'h0;
            next_stable = 1'b0;
        end else if (fast_tick && !stable) begin
            next_cnt = 16'(cnt + 16'h1);
            if (next_cnt >= 16'(STAB_TICKS)) begin
                next_stable = 1'b1;
            end
        end
    end

    // Register
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt    <= 16'h0;
            stable <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            stable <= next_stable;
        end
    end

endmodule // sccm_stab

/* core/sccm_top.sv */
// Purpose: System clock select, fast oscillator control and power-down mode entry
// Assumes: Oscillators arrive as synchronous tick pulses; CPU drives the register port
// Notes:   SYS_CLK_TICK marks each system clock edge; it is an enable, not a clock

module sccm_top
    import sccm_pkg::*;
#(
    parameter int unsigned STAB_TICKS = STAB_TICKS_DEF
)(
    // Clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              RESET,
    // Register port
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WR_DATA,
    input  wire logic              WR_STROBE,
    input  wire logic              RD_STROBE,
    output logic      [DATA_W-1:0] RD_DATA,
    // Oscillators
    input  wire logic              FAST_OSC_TICK,
    input  wire logic              SLOW_OSC_TICK,
    output logic                   FAST_OSC_ON,
    output logic                   SLOW_OSC_ON,
    // System clock
    output logic                   SYS_CLK_TICK,
    output logic      [2:0]        CLK_SEL_ACTIVE,
    output logic                   SWITCH_BUSY,
    // Power-down and watchdog
    input  wire logic              HALT_REQ,
    input  wire logic              WAKE_REQ,
    input  wire logic              WDT_ENABLE,
    input  wire logic              WDT_CLEAR_CMD,
    input  wire logic              WDT_TIMEOUT,
    output logic      [2:0]        PD_MODE,
    output logic                   POWER_DOWN_FLAG,
    output logic                   WDT_TIMEOUT_FLAG,
    output logic                   WDT_COUNT_CLEAR,
    // Interrupt
    output logic                   IRQ
);

    // ************************************************************************
    // Declarations
    // ************************************************************************
    sccm_ctrl_t     ctrl;
    sccm_ctrl_t     next_ctrl;
    sccm_sw_state_t sw_state;
    sccm_sw_state_t next_sw_state;
    sccm_pd_mode_t  pd_mode;
    sccm_pd_mode_t  next_pd_mode;
    logic [2:0]     active_sel;
    logic [2:0]     next_active_sel;
    logic [2:0]     pend_sel;
    logic [2:0]     next_pend_sel;
    logic [2:0]     sw_cnt;
    logic [2:0]     next_sw_cnt;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] next_irq_en;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_set;
    logic [DATA_W-1:0] next_rd_data;
    logic           next_pdf;
    logic           next_to;
    logic           next_wdt_clr;
    logic           next_irq;
    logic           next_fast_on;
    logic           next_slow_on;
    logic           next_sys_tick;
    logic           div_tick;
    logic           cur_tick;
    logic           tgt_tick;
    logic           stable;
    logic           stable_d;
    logic           restart;
    logic           ctrl_wr;
    logic           sel_change;
    logic           halt_take;
    logic           switch_done;
    logic           running;
    sccm_ctrl_t     wr_ctrl;

    // ************************************************************************
    // Submodules
    // ************************************************************************

    // Fast clock divided by the active ratio
    sccm_divider u_div (
        .clk        (SYS_CLK),
        .rst        (RESET),
        .fast_tick  (FAST_OSC_TICK),
        .ratio_code (active_sel),
        .div_tick   (div_tick)
    );

    // Settling tracker for the fast oscillator
    sccm_stab #(
        .STAB_TICKS (STAB_TICKS)
    ) u_stab (
        .clk        (SYS_CLK),
        .rst        (RESET),
        .osc_on     (FAST_OSC_ON),
        .restart    (restart),
        .fast_tick  (FAST_OSC_TICK),
        .stable     (stable)
    );

    // ************************************************************************
    // Decode and events
    // ************************************************************************

    // Write decode; the register port never stalls
    always_comb begin
        running    = (pd_mode == PD_RUN);
        ctrl_wr    = WR_STROBE && (ADDR == OFF_CTRL);
        wr_ctrl    = sccm_ctrl_t'(WR_DATA);
        sel_change = ctrl_wr && (wr_ctrl.sys_clk_select != ctrl.sys_clk_select);
        restart    = (ctrl_wr && wr_ctrl.fast_osc_enable && !ctrl.fast_osc_enable) || sel_change;
        irq_clr    = (WR_STROBE && (ADDR == OFF_IRQ_CLR)) ? WR_DATA[IRQ_W-1:0] : IRQ_NONE;
        halt_take  = HALT_REQ && running;
    end

    always_comb begin
        cur_tick = (active_sel == SEL_SLOW) ? SLOW_OSC_TICK : div_tick;
        tgt_tick = (pend_sel == SEL_SLOW) ? SLOW_OSC_TICK : FAST_OSC_TICK;
    end

    // ************************************************************************
    // Control register
    // ************************************************************************

    // Writable fields take the write; stable bit follows hardware
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_wr) begin
            next_ctrl = sccm_ctrl_t'((WR_DATA & CTRL_WR_MASK) | (ctrl & ~CTRL_WR_MASK));
        end
        next_ctrl.unused = 1'b0;
        next_ctrl.fast_osc_stable_flag = stable && !restart;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctrl     <= sccm_ctrl_t'(CTRL_RESET);
            stable_d <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            stable_d <= stable;
        end
    end

    // ************************************************************************
    // Clock switch sequencer
    // ************************************************************************

    // Wait four current edges, then one target edge, then hand over
    always_comb begin
        next_sw_state   = sw_state;
        next_sw_cnt     = sw_cnt;
        next_pend_sel   = pend_sel;
        next_active_sel = active_sel;
        switch_done     = 1'b0;
        if (sel_change) begin
            // A new select restarts the wait with the newest target
            next_pend_sel = wr_ctrl.sys_clk_select;
            next_sw_cnt   = 3'h0;
            next_sw_state = SW_CUR;
        end else begin
            unique case (sw_state)
                SW_IDLE: begin
                    next_sw_cnt = 3'h0;
                end
                SW_CUR: begin
                    if (cur_tick) begin
                        next_sw_cnt = 3'(sw_cnt + 3'h1);
                        if (next_sw_cnt == SW_CUR_TICKS) begin
                            next_sw_state = SW_TGT;
                        end
                    end
                end
                SW_TGT: begin
                    if (tgt_tick) begin
                        next_active_sel = pend_sel;
                        next_sw_state   = SW_IDLE;
                        switch_done     = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            sw_state   <= SW_IDLE;
            sw_cnt     <= 3'h0;
            pend_sel   <= SEL_RESET;
            active_sel <= SEL_RESET;
        end else begin
            sw_state   <= next_sw_state;
            sw_cnt     <= next_sw_cnt;
            pend_sel   <= next_pend_sel;
            active_sel <= next_active_sel;
        end
    end

    // ************************************************************************
    // Power-down entry and wake
    // ************************************************************************

    // Mode and watchdog flags
    always_comb begin
        next_pd_mode = pd_mode;
        next_pdf     = POWER_DOWN_FLAG;
        next_to      = WDT_TIMEOUT_FLAG;
        next_wdt_clr = 1'b0;
        if (WDT_CLEAR_CMD) begin
            next_pdf = 1'b0;
        end
        if (WDT_TIMEOUT) begin
            next_to = 1'b1;
        end
        if (!running && WAKE_REQ) begin
            next_pd_mode = PD_RUN;
        end
        if (halt_take) begin
            unique case ({ctrl.fast_osc_keep_in_halt, ctrl.slow_osc_keep_in_halt})
                2'b00: next_pd_mode = PD_SLEEP;
                2'b01: next_pd_mode = PD_IDLE0;
                2'b11: next_pd_mode = PD_IDLE1;
                2'b10: next_pd_mode = PD_IDLE2;
            endcase
            next_pdf     = 1'b1;
            next_to      = 1'b0;
            next_wdt_clr = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            pd_mode          <= PD_RUN;
            POWER_DOWN_FLAG  <= 1'b0;
            WDT_TIMEOUT_FLAG <= 1'b0;
            WDT_COUNT_CLEAR  <= 1'b0;
        end else begin
            pd_mode          <= next_pd_mode;
            POWER_DOWN_FLAG  <= next_pdf;
            WDT_TIMEOUT_FLAG <= next_to;
            WDT_COUNT_CLEAR  <= next_wdt_clr;
        end
    end

    // ************************************************************************
    // Oscillator and clock outputs
    // ************************************************************************

    // Fast runs when enabled or needed; in halt only its keep bit counts, while slow also follows the watchdog
    always_comb begin
        if (running) begin
            next_fast_on = ctrl.fast_osc_enable || (active_sel != SEL_SLOW) ||
                           (sw_state != SW_IDLE && pend_sel != SEL_SLOW);
            next_slow_on = 1'b1;
        end else begin
            next_fast_on = ctrl.fast_osc_keep_in_halt;
            // slow kept in halt; watchdog also holds it
            next_slow_on = ctrl.slow_osc_keep_in_halt || WDT_ENABLE;
        end
        // CPU clock stops in every halt state
        next_sys_tick = cur_tick && running;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            FAST_OSC_ON    <= 1'b0;
            SLOW_OSC_ON    <= 1'b1;
            SYS_CLK_TICK   <= 1'b0;
            CLK_SEL_ACTIVE <= SEL_RESET;
            SWITCH_BUSY    <= 1'b0;
            PD_MODE        <= PD_RUN;
        end else begin
            FAST_OSC_ON    <= next_fast_on;
            SLOW_OSC_ON    <= next_slow_on;
            SYS_CLK_TICK   <= next_sys_tick;
            CLK_SEL_ACTIVE <= next_active_sel;
            SWITCH_BUSY    <= (next_sw_state != SW_IDLE);
            PD_MODE        <= next_pd_mode;
        end
    end

    // ************************************************************************
    // Interrupts and read data
    // ************************************************************************

    // Sticky status: a set in the clearing cycle wins
    always_comb begin
        irq_set               = IRQ_NONE;
        irq_set[IRQ_STABLE]   = stable && !stable_d;
        irq_set[IRQ_SWITCHED] = switch_done;
        irq_set[IRQ_HALTED]   = halt_take;
        next_irq_stat         = (irq_stat & ~irq_clr) | irq_set;
        next_irq_en           = (WR_STROBE && ADDR == OFF_IRQ_EN) ? WR_DATA[IRQ_W-1:0] : irq_en;
        next_irq              = |(next_irq_stat & next_irq_en);
        next_rd_data          = DATA_ZERO;
        if (RD_STROBE) begin
            unique case (ADDR)
                OFF_CTRL:     next_rd_data = ctrl;
                OFF_IRQ_STAT: next_rd_data = DATA_W'(irq_stat);
                OFF_IRQ_EN:   next_rd_data = DATA_W'(irq_en);
                default:      next_rd_data = DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            irq_stat <= IRQ_NONE;
            irq_en   <= IRQ_NONE;
            IRQ      <= 1'b0;
            RD_DATA  <= DATA_ZERO;
        end else begin
            irq_stat <= next_irq_stat;
            irq_en   <= next_irq_en;
            IRQ      <= next_irq;
            RD_DATA  <= next_rd_data;
        end
    end

endmodule // sccm_top

/* test/sccm_top_props.sv */
// Purpose: Port-level checks for the system clock mode control block
// Assumes: Single SYS_CLK domain, synchronous active-high RESET
// Notes:   Bound to sccm_top from the testbench top file

// ****************************************
// Checker
// ****************************************
module sccm_top_props
    import sccm_pkg::*;
#(
    parameter int unsigned STAB_TICKS = STAB_TICKS_DEF
)(
    // Clock and reset
    input wire logic              SYS_CLK,
    input wire logic              RESET,
    // Register port
    input wire logic              RD_STROBE,
    input wire logic [DATA_W-1:0] RD_DATA,
    // Oscillators and system clock
    input wire logic              FAST_OSC_ON,
    input wire logic              SLOW_OSC_ON,
    input wire logic              SYS_CLK_TICK,
    input wire logic [2:0]        CLK_SEL_ACTIVE,
    input wire logic              SWITCH_BUSY,
    // Power-down and watchdog
    input wire logic              HALT_REQ,
    input wire logic              WDT_ENABLE,
    input wire logic              WDT_CLEAR_CMD,
    input wire logic [2:0]        PD_MODE,
    input wire logic              POWER_DOWN_FLAG,
    input wire logic              WDT_TIMEOUT_FLAG,
    input wire logic              WDT_COUNT_CLEAR
);
    timeunit 1ns;
    timeprecision 1ns;
    // Longest switch seen with the bench oscillator periods, with margin
    localparam int SW_MAX = 600;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    // Halt accepted in run, and the state it must leave behind
    sequence halt_s;
        HALT_REQ && PD_MODE == 3'h0;
    endsequence
    sequence entry_s;
        PD_MODE != 3'h0 && POWER_DOWN_FLAG && !WDT_TIMEOUT_FLAG && WDT_COUNT_CLEAR;
    endsequence

    halt_entry_a: assert property (halt_s |=> entry_s)
        else $error("halt entry flags wrong");
    clr_pulse_a: assert property (WDT_COUNT_CLEAR |-> $past(HALT_REQ) && $past(PD_MODE) == 3'h0 ##1 !WDT_COUNT_CLEAR)
        else $error("watchdog clear pulse without halt");
    halt_tick_a: assert property (PD_MODE != 3'h0 && $past(PD_MODE) != 3'h0 |-> !SYS_CLK_TICK)
        else $error("system tick while halted");
    sel_busy_a: assert property ($changed(CLK_SEL_ACTIVE) |-> $fell(SWITCH_BUSY))
        else $error("select changed apart from switch end");
    sw_bound_a: assert property ($rose(SWITCH_BUSY) |-> ##[1:SW_MAX] !SWITCH_BUSY)
        else $error("clock switch too slow");
    rd_idle_a: assert property (!$past(RD_STROBE) |-> RD_DATA == DATA_ZERO)
        else $error("read data outside read slot");
    pd_clear_a: assert property (WDT_CLEAR_CMD && !(HALT_REQ && PD_MODE == 3'h0) |=> !POWER_DOWN_FLAG)
        else $error("power-down flag not cleared");
    halt_osc_a: assert property (PD_MODE != 3'h0 && PD_MODE == $past(PD_MODE) |->
        FAST_OSC_ON == (PD_MODE == PD_IDLE1 || PD_MODE == PD_IDLE2) &&
        SLOW_OSC_ON == (PD_MODE == PD_IDLE0 || PD_MODE == PD_IDLE1 || $past(WDT_ENABLE)))
        else $error("oscillator run state wrong in halt");
endmodule // sccm_top_props

/* test/sccm_osc_model.sv */
// Purpose: Oscillator sources feeding tick pulses to the block
// Assumes: Each oscillator ticks only while its run request is high
// Notes:   Periods are in SYS_CLK cycles, far shorter than real parts

// ****************************************
// Oscillator model
// ****************************************
module sccm_osc_model #(
    parameter int FAST_P = 2,
    parameter int SLOW_P = 8
)(
    // Clock
    input  wire logic clk,
    // Run requests
    input  wire logic fast_on,
    input  wire logic slow_on,
    // Ticks
    output logic      fast_tick = 1'b0,
    output logic      slow_tick = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    int fast_cnt = 0;
    int slow_cnt = 0;

    // Free counters; a stopped oscillator gives no ticks at all
    always @(posedge clk) begin
        fast_cnt  <= (fast_cnt + 1) % FAST_P;
        slow_cnt  <= (slow_cnt + 1) % SLOW_P;
        fast_tick <= fast_on && fast_cnt == FAST_P - 1;
        slow_tick <= slow_on && slow_cnt == SLOW_P - 1;
    end
endmodule // sccm_osc_model

/* test/testbench.sv */
// Purpose: Self-checking bench for the system clock mode control block
// Assumes: Oscillator model drives the tick inputs
// Notes:   Expectations come from small integer models below

// ****************************************
// Bench
// ****************************************
module testbench
    import sccm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FAST_P = 2;
    localparam int SLOW_P = 8;
    logic       sys_clk = 1'b0, reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00, rd_data, d;
    logic       wr_strobe = 1'b0, rd_strobe = 1'b0, halt_req = 1'b0, wake_req = 1'b0;
    logic       wdt_en = 1'b0, wdt_clr = 1'b0, wdt_to = 1'b0;
    logic       fast_tick, slow_tick, fast_on, slow_on, sys_tick, busy, power_down_flag, tof, wcc, irq;
    logic [2:0] sel_act, pd_mode;
    int         bad_count = 0, check_count = 0, cyc = 0;

    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    sccm_top #(.STAB_TICKS(4)) sccm_top_inst (.SYS_CLK(sys_clk), .RESET(reset), .ADDR(addr),
        .WR_DATA(wr_data), .WR_STROBE(wr_strobe), .RD_STROBE(rd_strobe), .RD_DATA(rd_data),
        .FAST_OSC_TICK(fast_tick), .SLOW_OSC_TICK(slow_tick), .FAST_OSC_ON(fast_on),
        .SLOW_OSC_ON(slow_on), .SYS_CLK_TICK(sys_tick), .CLK_SEL_ACTIVE(sel_act),
        .SWITCH_BUSY(busy), .HALT_REQ(halt_req), .WAKE_REQ(wake_req), .WDT_ENABLE(wdt_en),
        .WDT_CLEAR_CMD(wdt_clr), .WDT_TIMEOUT(wdt_to), .PD_MODE(pd_mode),
        .POWER_DOWN_FLAG(power_down_flag), .WDT_TIMEOUT_FLAG(tof), .WDT_COUNT_CLEAR(wcc), .IRQ(irq));
    sccm_osc_model #(.FAST_P(FAST_P), .SLOW_P(SLOW_P)) sccm_osc_model_inst (.clk(sys_clk),
        .fast_on(fast_on), .slow_on(slow_on), .fast_tick(fast_tick), .slow_tick(slow_tick));

    // Register port: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr <= a; wr_data <= v; wr_strobe <= 1'b1;
        @(posedge sys_clk);
        wr_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        addr <= a; rd_strobe <= 1'b1;
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
        #1 v = rd_data;
    endtask
    // One-cycle pulse on a CPU event line: 0 halt, 1 wake, 2 clear, 3 timeout
    task automatic pulse(input int w);
        @(posedge sys_clk);
        case (w)
            0: halt_req <= 1'b1;
            1: wake_req <= 1'b1;
            2: wdt_clr <= 1'b1;
            default: wdt_to <= 1'b1;
        endcase
        @(posedge sys_clk);
        {halt_req, wake_req, wdt_clr, wdt_to} <= 4'h0;
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("mismatch %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic close_out();
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Tick period of a select code in SYS_CLK cycles
    function automatic int per(input int c);
        return (c == 7) ? SLOW_P : (FAST_P << c);
    endfunction
    // Halt state expected from the keep bits {fast, slow}
    function automatic logic [7:0] exp_mode(input int k);
        case (k)
            0: return 8'h01;
            1: return 8'h02;
            3: return 8'h03;
            default: return 8'h04;
        endcase
    endfunction

    // Hang guard, well beyond the longest expected run
    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        close_out();
    end

    initial begin
        int unsigned r;
        int t0, n, c, k;
        r = $urandom(73);
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        rd(OFF_CTRL, d);
        chk(d, CTRL_RESET);
        chk({5'h0, sel_act}, 8'h07);
        wr(OFF_CTRL, 8'hFC);
        rd(OFF_CTRL, d);
        chk(d, 8'hE4);
        repeat (20) @(posedge sys_clk);
        rd(OFF_CTRL, d);
        chk(d, 8'hEC);
        for (int i = 0; i < 6; i++) begin
            r = $urandom;
            wr(OFF_CTRL, {3'h7, r[4:3], 1'b1, r[1:0]});
            rd(OFF_CTRL, d);
            chk(d & 8'hF7, {6'h39, r[1:0]});
        end
        // Walk every select code, timing each switch and counting system ticks
        for (c = 0; c < 8; c++) begin
            wr(OFF_CTRL, {c[2:0], 5'h04});
            t0 = cyc;
            rd(OFF_CTRL, d);
            chk(d, {c[2:0], 5'h04});
            // Look just after each edge so the busy level seen is the settled one
            while (busy === 1'b1 && cyc - t0 < 2000) begin
                @(posedge sys_clk);
                #1;
            end
            // Bound is 4 current + 1.5 current + 0.5 target periods, plus cycle granularity
            chk_rng(cyc - t0, 3 * per((c + 7) % 8), (11 * per((c + 7) % 8) + per(c)) / 2 + 3);
            chk({5'h0, sel_act}, {5'h0, c[2:0]});
            n = 0;
            repeat (256) begin
                @(posedge sys_clk);
                #1;
                if (sys_tick === 1'b1) n++;
            end
            chk_rng(n, 256 / per(c) - 1, 256 / per(c) + 1);
        end
        // Every keep-bit setting, with a stale timeout flag to be cleared
        for (k = 0; k < 4; k++) begin
            wr(OFF_CTRL, {6'h38, k[1:0]});
            wdt_en <= 1'($urandom);
            pulse(3);
            pulse(0);
            chk({5'h0, pd_mode}, exp_mode(k));
            chk({5'h0, power_down_flag, tof, wcc}, 8'h05);
            @(posedge sys_clk);
            #1;
            chk({6'h0, fast_on, slow_on}, {6'h0, k[1], k[0] | wdt_en});
            pulse(0);
            chk({4'h0, pd_mode, wcc}, exp_mode(k) << 1);
            pulse(1);
            chk({5'h0, pd_mode}, 8'h00);
            pulse(2);
            chk({7'h0, power_down_flag}, 8'h00);
        end
        // Sticky status, masking, unmapped and write-only reads
        wr(OFF_IRQ_EN, 8'h00);
        rd(OFF_IRQ_STAT, d);
        chk(d, 8'h07);
        wr(OFF_IRQ_CLR, 8'h07);
        rd(OFF_IRQ_STAT, d);
        chk(d, 8'h00);
        pulse(0);
        pulse(1);
        chk({7'h0, irq}, 8'h00);
        wr(OFF_IRQ_EN, 8'h04);
        @(posedge sys_clk);
        #1;
        chk({7'h0, irq}, 8'h01);
        rd(OFF_IRQ_EN, d);
        chk(d, 8'h04);
        rd(4'hA, d);
        chk(d, 8'h00);
        rd(OFF_IRQ_CLR, d);
        chk(d, 8'h00);
        wr(OFF_IRQ_CLR, 8'h04);
        @(posedge sys_clk);
        #1;
        chk({7'h0, irq}, 8'h00);
        close_out();
    end
endmodule // testbench

bind sccm_top sccm_top_props #(.STAB_TICKS(STAB_TICKS)) sccm_top_props_inst (.SYS_CLK(SYS_CLK),
    .RESET(RESET), .RD_STROBE(RD_STROBE), .RD_DATA(RD_DATA), .FAST_OSC_ON(FAST_OSC_ON),
    .SLOW_OSC_ON(SLOW_OSC_ON), .SYS_CLK_TICK(SYS_CLK_TICK), .CLK_SEL_ACTIVE(CLK_SEL_ACTIVE),
    .SWITCH_BUSY(SWITCH_BUSY), .HALT_REQ(HALT_REQ), .WDT_ENABLE(WDT_ENABLE),
    .WDT_CLEAR_CMD(WDT_CLEAR_CMD), .PD_MODE(PD_MODE), .POWER_DOWN_FLAG(POWER_DOWN_FLAG),
    .WDT_TIMEOUT_FLAG(WDT_TIMEOUT_FLAG), .WDT_COUNT_CLEAR(WDT_COUNT_CLEAR));
